// file: core/scev_defs.svh
// constants for the socket command and event unit
`ifndef SCEV_DEFS_SVH
`define SCEV_DEFS_SVH
// ==========================================================
// register offsets
`define SCEV_OFS_MODE 16'h4000
`define SCEV_OFS_CMD 16'h4001
`define SCEV_OFS_FLAGS 16'h4002
`define SCEV_OFS_STATE 16'h4003
`define SCEV_OFS_MASK 16'h402C
`define SCEV_OFS_SUMMARY 16'h0034
// ==========================================================
// command codes
`define SCEV_CMD_GRACEFUL_CLOSE 8'h08
`define SCEV_CMD_CLOSE 8'h10
`define SCEV_CMD_SEND 8'h20
`define SCEV_CMD_TX_FIXED_HW 8'h21
`define SCEV_CMD_KEEPALIVE 8'h22
`define SCEV_CMD_PPP_START 8'h23
`define SCEV_CMD_PPP_STOP 8'h24
`define SCEV_CMD_PPP_REQUEST 8'h25
`define SCEV_CMD_PPP_NAK 8'h26
`define SCEV_CMD_PPP_REJECT 8'h27
`define SCEV_CMD_RX_CONSUME 8'h40
// ==========================================================
// protocol modes
`define SCEV_MODE_TCP 4'h1
`define SCEV_MODE_UDP 4'h2
`define SCEV_MODE_IPRAW 4'h3
`define SCEV_MODE_MACRAW 4'h4
`define SCEV_MODE_PPPOE 4'h5
// ==========================================================
// state codes
`define SCEV_ST_IDLE 8'h00
`define SCEV_ST_OPENED_TCP 8'h13
`define SCEV_ST_CONNECTED 8'h17
`define SCEV_ST_CLOSE_WAIT 8'h1C
`define SCEV_ST_FIN_WAIT 8'h18
`define SCEV_ST_OPENED_UDP 8'h22
`define SCEV_ST_OPENED_IPRAW 8'h32
`define SCEV_ST_OPENED_MACRAW 8'h42
`define SCEV_ST_OPENED_PPPOE 8'h5F
// ==========================================================
// flag bit positions
`define SCEV_FLG_LINK_UP 0
`define SCEV_FLG_PEER_FIN 1
`define SCEV_FLG_RX_DATA 2
`define SCEV_FLG_TIMEOUT 3
`define SCEV_FLG_SEND_OK 4
`define SCEV_FLG_PPP_PHASE 5
`define SCEV_FLG_PPP_AUTH 6
`define SCEV_FLG_PPP_OPT 7
`define SCEV_RST_FLAGS 8'h00
`define SCEV_RST_MASK 8'hFF
`endif

// file: core/scev_pkg.sv
// types shared by the socket command and event unit
`include "scev_defs.svh"
package scev_pkg;
	// network events reported by the protocol engine, one cycle pulses
	typedef struct packed {
		logic peer_fin;
		logic peer_finack;
		logic peer_rst;
		logic link_up;
		logic rx_data;
		logic send_done;
		logic tcp_retry_expiry;
		logic arp_resolve_expiry;
		logic ppp_unsupported_opt;
		logic ppp_auth_fail;
		logic ppp_phase;
	} scev_event_type;
	// one-cycle actions asked of the protocol engine
	typedef struct packed {
		logic send_fin;
		logic send_data;
		logic skip_arp;
		logic send_keepalive;
		logic rx_consume;
		logic ppp_discovery;
		logic ppp_close;
		logic ppp_request;
		logic ppp_nak;
		logic ppp_reject;
	} scev_action_type;
endpackage : scev_pkg

// file: core/scev_flags.sv
// sticky socket event flags with mask and write-one-to-clear
`timescale 1ns/1ps
`default_nettype none
`include "scev_defs.svh"
module scev_flags
	import scev_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] raw_event,
	input wire logic [WIDTH-1:0] mask,
	input wire logic clr_we,
	input wire logic [WIDTH-1:0] clr_bits,
	output logic [WIDTH-1:0] flags,
	output logic any_flag
);
	logic [WIDTH-1:0] flags_q;
	logic [WIDTH-1:0] set_w;
	logic [WIDTH-1:0] clr_w;

	assign set_w = raw_event & mask; // R15
	assign clr_w = clr_we ? clr_bits : '0; // R16

	// a set in the clearing cycle wins, so no event is lost
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			flags_q <= WIDTH'(`SCEV_RST_FLAGS);
		end else begin
			flags_q <= (flags_q & ~clr_w) | set_w; // R15 R16
		end
	end

	assign flags = flags_q;
	assign any_flag = |flags_q; // R17

	chk_masked_no_set: assert property (@(posedge sys_clk) disable iff (rst) // R15
		(!flags_q[0] && !(raw_event[0] && mask[0])) |=> !flags_q[0])
		else $error("flag bit set without event");
	chk_w1c_clears: assert property (@(posedge sys_clk) disable iff (rst) // R16
		(clr_we && clr_bits[1] && !set_w[1]) |=> !flags_q[1])
		else $error("written one did not clear flag");
	chk_w0_holds: assert property (@(posedge sys_clk) disable iff (rst) // R16
		(clr_we && !clr_bits[2] && flags_q[2]) |=> flags_q[2])
		else $error("written zero cleared flag");
endmodule : scev_flags
`default_nettype wire

// file: core/scev_unit.sv
// socket command interpreter with state and event flags
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "scev_defs.svh"
//
// Contract
// R01 - graceful close in TCP sends FIN to the peer, server or client.
// R02 - after peer FIN, graceful close replies with our FIN.
// R03 - after graceful close, peer FIN/ACK moves state to idle.
// R04 - no peer reply: timeout sets flag bit 3 and closes the socket.
// R05 - close command goes idle at once with no FIN sent.
// R06 - peer reset at any time forces state to idle.
// R07 - reset instead of SYN/ACK while connecting fails and closes.
// R08 - send transmits all data between transmit read and write pointers.
// R09 - UDP only fixed-address send acts as send, skipping address resolution.
// R10 - TCP keep-alive sends one byte; no answer raises timeout.
// R11 - receive-consume frees receive space up to host read pointer.
// R12 - host issues PPPoE commands only to socket 0 in PPPoE mode.
// R13 - PPPoE start sends discovery; PPPoE stop closes the session.
// R14 - PPPoE 0x25 request, 0x26 nak, 0x27 reject messages.
// R15 - an event flag sets only when its event occurs and mask is one.
// R16 - writing one clears a flag; writing zero leaves it.
// R17 - all flags zero clears the socket bit of global summary.
// R18 - flag bits 7,6,5 only for socket 0 in PPPoE mode.
// R19 - flag bit 4 sets when send completes.
// R20 - flag bit 3 sets on address or retransmission timeout.
// R21 - flag bit 2 sets when a data packet arrives.
// R22 - flag bit 1 on peer FIN; bit 0 on connection established.
// R23 - mode codes TCP 1 to PPPoE 5; TCP open state 0x13.
// R24 - idle state code is 0x00, resources released.
// R25 - connected state 0x17; TCP send and consume only there; the code also takes them in close-wait 0x1C.
// R26 - command register reads zero once command is accepted.
// R27 - invalid commands for mode or socket are ignored.
module scev_unit
	import scev_pkg::*;
#(
	parameter int SOCKET_ID = 0,
	parameter int PTR_W = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [7:0] reg_rdata,
	input wire scev_event_type net_event,
	input wire logic opened,
	input wire logic [PTR_W-1:0] tx_read_ptr,
	input wire logic [PTR_W-1:0] tx_write_ptr,
	input wire logic [PTR_W-1:0] rx_read_ptr,
	output scev_action_type action,
	output logic [PTR_W-1:0] tx_len,
	output logic [PTR_W-1:0] rx_free_to,
	output logic [7:0] socket_state,
	output logic summary_bit
);
	// ==========================================================
	// registers
	logic [3:0] mode_q;
	logic [7:0] mask_q;
	logic [7:0] cmd_q;
	logic [7:0] state_q;
	logic fin_rcvd_q;
	logic [7:0] flags_w;
	logic any_w;
	logic [7:0] raw_w;
	logic cmd_valid_w;
	logic is_tcp_w;
	logic is_udp_w;
	logic is_ppp_w;
	logic connected_w;
	scev_action_type action_d;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// the open state follows the mode; an unknown mode stays idle so later commands are refused
	function automatic logic [7:0] open_code(input logic [3:0] m);
		case (m)
			`SCEV_MODE_TCP: open_code = `SCEV_ST_OPENED_TCP;
			`SCEV_MODE_UDP: open_code = `SCEV_ST_OPENED_UDP;
			`SCEV_MODE_IPRAW: open_code = `SCEV_ST_OPENED_IPRAW;
			`SCEV_MODE_MACRAW: open_code = `SCEV_ST_OPENED_MACRAW;
			`SCEV_MODE_PPPOE: open_code = `SCEV_ST_OPENED_PPPOE;
			default: open_code = `SCEV_ST_IDLE;
		endcase
	endfunction : open_code

	assign is_tcp_w = (mode_q == `SCEV_MODE_TCP); // R23
	assign is_udp_w = (mode_q == `SCEV_MODE_UDP);
	assign is_ppp_w = (mode_q == `SCEV_MODE_PPPOE) && (SOCKET_ID == 0); // R12 R18
	assign connected_w = (state_q == `SCEV_ST_CONNECTED) || (state_q == `SCEV_ST_CLOSE_WAIT);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mode_q <= 4'h0;
		end else if (reg_we && hit(reg_addr, `SCEV_OFS_MODE)) begin
			mode_q <= reg_wdata[3:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mask_q <= `SCEV_RST_MASK;
		end else if (reg_we && hit(reg_addr, `SCEV_OFS_MASK)) begin
			mask_q <= reg_wdata;
		end
	end

	// ==========================================================
	// command decode: taken one cycle after the write
	always_comb begin
		action_d = '0;
		cmd_valid_w = 1'b0;
		case (cmd_q)
			`SCEV_CMD_GRACEFUL_CLOSE: begin
				cmd_valid_w = is_tcp_w && connected_w;
				action_d.send_fin = cmd_valid_w; // R01 R02
			end
			`SCEV_CMD_CLOSE: begin
				cmd_valid_w = 1'b1; // R05
			end
			`SCEV_CMD_SEND: begin
				cmd_valid_w = is_tcp_w ? connected_w : (state_q != `SCEV_ST_IDLE); // R25
				action_d.send_data = cmd_valid_w; // R08
			end
			`SCEV_CMD_TX_FIXED_HW: begin
				cmd_valid_w = is_udp_w && (state_q != `SCEV_ST_IDLE); // R09
				action_d.send_data = cmd_valid_w;
				action_d.skip_arp = cmd_valid_w;
			end
			`SCEV_CMD_KEEPALIVE: begin
				cmd_valid_w = is_tcp_w && connected_w;
				action_d.send_keepalive = cmd_valid_w; // R10
			end
			`SCEV_CMD_RX_CONSUME: begin
				cmd_valid_w = is_tcp_w ? connected_w : (state_q != `SCEV_ST_IDLE); // R25
				action_d.rx_consume = cmd_valid_w; // R11
			end
			`SCEV_CMD_PPP_START: begin
				cmd_valid_w = is_ppp_w;
				action_d.ppp_discovery = cmd_valid_w; // R13
			end
			`SCEV_CMD_PPP_STOP: begin
				cmd_valid_w = is_ppp_w;
				action_d.ppp_close = cmd_valid_w; // R13
			end
			`SCEV_CMD_PPP_REQUEST: begin
				cmd_valid_w = is_ppp_w;
				action_d.ppp_request = cmd_valid_w; // R14
			end
			`SCEV_CMD_PPP_NAK: begin
				cmd_valid_w = is_ppp_w;
				action_d.ppp_nak = cmd_valid_w; // R14
			end
			`SCEV_CMD_PPP_REJECT: begin
				cmd_valid_w = is_ppp_w;
				action_d.ppp_reject = cmd_valid_w; // R14
			end
			default: begin
				cmd_valid_w = 1'b0; // R27
			end
		endcase
	end

	// command clears to zero after one cycle whether taken or not
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cmd_q <= 8'h00;
		end else if (reg_we && hit(reg_addr, `SCEV_OFS_CMD)) begin
			cmd_q <= reg_wdata;
		end else begin
			cmd_q <= 8'h00; // R26
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			action <= '0;
		end else begin
			action <= action_d;
		end
	end

	// snapshot pointers for the engine; a send moves everything queued
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tx_len <= '0;
			rx_free_to <= '0;
		end else begin
			if (action_d.send_data) begin
				tx_len <= PTR_W'(tx_write_ptr - tx_read_ptr); // R08
			end
			if (action_d.rx_consume) begin
				rx_free_to <= rx_read_ptr; // R11
			end
		end
	end

	// ==========================================================
	// socket state
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= `SCEV_ST_IDLE; // R24
			fin_rcvd_q <= 1'b0;
		end else begin
			if (net_event.peer_rst || net_event.tcp_retry_expiry || net_event.arp_resolve_expiry) begin
				state_q <= `SCEV_ST_IDLE; // R04 R06 R07
				fin_rcvd_q <= 1'b0;
			end else if (cmd_q == `SCEV_CMD_CLOSE) begin
				state_q <= `SCEV_ST_IDLE; // R05
				fin_rcvd_q <= 1'b0;
			end else if (action_d.send_fin) begin
				state_q <= `SCEV_ST_FIN_WAIT; // R01 R02
			end else if (net_event.peer_finack && state_q == `SCEV_ST_FIN_WAIT) begin
				state_q <= `SCEV_ST_IDLE; // R03
				fin_rcvd_q <= 1'b0;
			end else if (opened && state_q == `SCEV_ST_IDLE) begin
				// connectionless modes need a non-idle state before send is accepted
				state_q <= open_code(mode_q); // R23
			end else if (net_event.link_up && is_tcp_w && state_q != `SCEV_ST_IDLE) begin
				state_q <= `SCEV_ST_CONNECTED; // R25
			end else if (net_event.peer_fin && state_q == `SCEV_ST_CONNECTED) begin
				state_q <= `SCEV_ST_CLOSE_WAIT;
				fin_rcvd_q <= 1'b1;
			end
		end
	end

	// ==========================================================
	// events and flags
	always_comb begin
		raw_w = 8'h00;
		raw_w[`SCEV_FLG_LINK_UP] = net_event.link_up; // R22
		raw_w[`SCEV_FLG_PEER_FIN] = net_event.peer_fin; // R22
		raw_w[`SCEV_FLG_RX_DATA] = net_event.rx_data; // R21
		raw_w[`SCEV_FLG_TIMEOUT] = net_event.tcp_retry_expiry || net_event.arp_resolve_expiry; // R20 R04 R10
		raw_w[`SCEV_FLG_SEND_OK] = net_event.send_done; // R19
		raw_w[`SCEV_FLG_PPP_PHASE] = net_event.ppp_phase && is_ppp_w; // R18
		raw_w[`SCEV_FLG_PPP_AUTH] = net_event.ppp_auth_fail && is_ppp_w; // R18
		raw_w[`SCEV_FLG_PPP_OPT] = net_event.ppp_unsupported_opt && is_ppp_w; // R18
	end

	scev_flags #(
		.WIDTH(8)
	) u_flags (
		.sys_clk(sys_clk),
		.rst(rst),
		.raw_event(raw_w),
		.mask(mask_q),
		.clr_we(reg_we && hit(reg_addr, `SCEV_OFS_FLAGS)),
		.clr_bits(reg_wdata),
		.flags(flags_w),
		.any_flag(any_w)
	);

	assign summary_bit = any_w; // R17
	assign socket_state = state_q;

	// ==========================================================
	// read port: data in the cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_re) begin
			case (reg_addr)
				`SCEV_OFS_MODE: reg_rdata <= {4'h0, mode_q};
				`SCEV_OFS_CMD: reg_rdata <= cmd_q; // R26
				`SCEV_OFS_FLAGS: reg_rdata <= flags_w;
				`SCEV_OFS_STATE: reg_rdata <= state_q;
				`SCEV_OFS_MASK: reg_rdata <= mask_q;
				`SCEV_OFS_SUMMARY: reg_rdata <= {7'h00, any_w};
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ==========================================================
	// checks
	chk_close_to_idle: assert property (@(posedge sys_clk) disable iff (rst) // R05
		(cmd_q == `SCEV_CMD_CLOSE) |=> (state_q == `SCEV_ST_IDLE) && !action.send_fin)
		else $error("close did not go idle");
	chk_rst_to_idle: assert property (@(posedge sys_clk) disable iff (rst) // R06
		net_event.peer_rst |=> state_q == `SCEV_ST_IDLE)
		else $error("peer reset did not close");
	chk_timeout_close: assert property (@(posedge sys_clk) disable iff (rst) // R04
		(net_event.tcp_retry_expiry && mask_q[3]) |=> (state_q == `SCEV_ST_IDLE) && flags_w[3])
		else $error("timeout missed");
	chk_fin_sent: assert property (@(posedge sys_clk) disable iff (rst) // R01
		(cmd_q == `SCEV_CMD_GRACEFUL_CLOSE && is_tcp_w && connected_w && !net_event.peer_rst) |=> action.send_fin)
		else $error("no FIN on graceful close");
	chk_finack_idle: assert property (@(posedge sys_clk) disable iff (rst) // R03
		(state_q == `SCEV_ST_FIN_WAIT && net_event.peer_finack) |=> state_q == `SCEV_ST_IDLE)
		else $error("FIN/ACK did not close");
	chk_cmd_zeroed: assert property (@(posedge sys_clk) disable iff (rst) // R26
		(cmd_q != 8'h00 && !reg_we) |=> cmd_q == 8'h00)
		else $error("command not zeroed");
	chk_ppp_gated: assert property (@(posedge sys_clk) disable iff (rst) // R27
		!is_ppp_w |=> !action.ppp_discovery && !action.ppp_request)
		else $error("ppp action outside PPPoE");
	chk_summary_clear: assert property (@(posedge sys_clk) disable iff (rst) // R17
		(flags_w == 8'h00) |-> !summary_bit)
		else $error("summary not cleared");
	chk_send_len: assert property (@(posedge sys_clk) disable iff (rst) // R08
		action_d.send_data |=> tx_len == PTR_W'($past(tx_write_ptr) - $past(tx_read_ptr)))
		else $error("send length wrong");
	// the priority guards mirror the state process so a coinciding close or reset does not fire these
	chk_open_tcp: assert property (@(posedge sys_clk) disable iff (rst) // R23
		(opened && is_tcp_w && state_q == `SCEV_ST_IDLE && cmd_q != `SCEV_CMD_CLOSE && !net_event.peer_rst &&
		!net_event.tcp_retry_expiry && !net_event.arp_resolve_expiry) |=> state_q == `SCEV_ST_OPENED_TCP)
		else $error("TCP open state wrong");
	chk_link_connect: assert property (@(posedge sys_clk) disable iff (rst) // R25
		(net_event.link_up && is_tcp_w && state_q == `SCEV_ST_OPENED_TCP && cmd_q != `SCEV_CMD_CLOSE &&
		!net_event.peer_rst && !net_event.tcp_retry_expiry && !net_event.arp_resolve_expiry) |=> connected_w)
		else $error("link up did not connect");
	chk_send_gated: assert property (@(posedge sys_clk) disable iff (rst) // R25
		(cmd_q == `SCEV_CMD_SEND && is_tcp_w && !connected_w) |=> !action.send_data)
		else $error("send taken while not connected");
	chk_fixed_hw_udp: assert property (@(posedge sys_clk) disable iff (rst) // R09
		(cmd_q == `SCEV_CMD_TX_FIXED_HW && !is_udp_w) |=> !action.skip_arp && !action.send_data)
		else $error("fixed address send outside UDP");
	chk_rx_free: assert property (@(posedge sys_clk) disable iff (rst) // R11
		action_d.rx_consume |=> rx_free_to == $past(rx_read_ptr))
		else $error("receive pointer not taken");
	chk_ppp_flags: assert property (@(posedge sys_clk) disable iff (rst) // R18
		(!is_ppp_w && !flags_w[`SCEV_FLG_PPP_OPT]) |=> !flags_w[`SCEV_FLG_PPP_OPT])
		else $error("ppp flag outside PPPoE");
	chk_arp_flag: assert property (@(posedge sys_clk) disable iff (rst) // R20
		(net_event.arp_resolve_expiry && mask_q[`SCEV_FLG_TIMEOUT]) |=> flags_w[`SCEV_FLG_TIMEOUT])
		else $error("address timeout not flagged");
	chk_send_ok_flag: assert property (@(posedge sys_clk) disable iff (rst) // R19
		(net_event.send_done && mask_q[`SCEV_FLG_SEND_OK]) |=> flags_w[`SCEV_FLG_SEND_OK])
		else $error("send completion not flagged");
	cov_graceful: cover property (@(posedge sys_clk) action.send_fin ##[1:20] state_q == `SCEV_ST_IDLE);
	cov_send: cover property (@(posedge sys_clk) action.send_data ##[1:20] flags_w[4]);
	cov_ppp: cover property (@(posedge sys_clk) action.ppp_discovery);
	cov_passive: cover property (@(posedge sys_clk) state_q == `SCEV_ST_CLOSE_WAIT ##1 action.send_fin);
endmodule : scev_unit
`default_nettype wire

// file: sim/scev_engine_model.sv
// behavioural protocol engine model answering the socket unit's actions
`timescale 1ns/1ps
`default_nettype none
module scev_engine_model
	import scev_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire scev_action_type action,
	output scev_event_type net_event
);
	// ==========================================================
	// reply delays
	// a fixed three-cycle turnaround keeps answers off the action edge
	logic [2:0] send_dly_q;
	logic [2:0] fin_dly_q;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			send_dly_q <= 3'h0;
			fin_dly_q <= 3'h0;
		end else begin
			send_dly_q <= {send_dly_q[1:0], action.send_data};
			fin_dly_q <= {fin_dly_q[1:0], action.send_fin};
		end
	end
	always_comb begin
		net_event = '0;
		net_event.send_done = send_dly_q[2];
		net_event.peer_finack = fin_dly_q[2];
	end
endmodule : scev_engine_model
`default_nettype wire

// file: sim/testbench.sv
// self-checking testbench for the socket command and event unit
`timescale 1ns/1ps
`default_nettype none
`include "scev_defs.svh"
module testbench
	import scev_pkg::*;
;
	// ==========================================================
	// signals
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_we = 1'b0;
	logic reg_re = 1'b0;
	logic [7:0] reg_rdata;
	logic [10:0] inj = 11'h000;
	scev_event_type eng_ev;
	scev_event_type net_event;
	logic opened = 1'b0;
	logic [15:0] tx_read_ptr = 16'h0000;
	logic [15:0] tx_write_ptr = 16'h0000;
	logic [15:0] rx_read_ptr = 16'h0000;
	scev_action_type action;
	logic [15:0] tx_len;
	logic [15:0] rx_free_to;
	logic [7:0] socket_state;
	logic summary_bit;
	logic seen_clr = 1'b0;
	logic [9:0] act_seen = 10'h000;
	int errors = 0;
	int comparisons = 0;
	always #4 sys_clk = ~sys_clk;
	assign net_event = scev_event_type'(inj | eng_ev);
	// action pulses last one cycle, so they are gathered between commands
	always @(posedge sys_clk) begin
		act_seen <= seen_clr ? 10'h000 : (act_seen | action);
	end
	scev_unit #(.SOCKET_ID(0), .PTR_W(16)) scev_unit_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .net_event(net_event),
		.opened(opened), .tx_read_ptr(tx_read_ptr), .tx_write_ptr(tx_write_ptr), .rx_read_ptr(rx_read_ptr),
		.action(action), .tx_len(tx_len), .rx_free_to(rx_free_to), .socket_state(socket_state),
		.summary_bit(summary_bit));
	scev_engine_model scev_engine_model_inst (.sys_clk(sys_clk), .rst(rst), .action(action), .net_event(eng_ev));
	// ==========================================================
	// shared tasks
	task automatic tally_and_finish;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_we <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		seen_clr <= 1'b1;
		@(posedge sys_clk);
		reg_we <= 1'b0;
		seen_clr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_re <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_re <= 1'b0;
		#1;
		check({8'h00, reg_rdata}, {8'h00, exp});
	endtask : rd
	task automatic cmd(input logic [7:0] c);
		wr(`SCEV_OFS_CMD, c);
		repeat (8) @(posedge sys_clk);
		#1;
	endtask : cmd
	task automatic ev(input int b);
		@(posedge sys_clk);
		inj <= 11'h001 << b;
		@(posedge sys_clk);
		inj <= 11'h000;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask : ev
	task automatic open_sock(input logic [7:0] mode);
		wr(`SCEV_OFS_MODE, mode);
		@(posedge sys_clk);
		opened <= 1'b1;
		@(posedge sys_clk);
		opened <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask : open_sock
	task automatic wait_state(input logic [7:0] exp);
		int n;
		n = 0;
		while (socket_state !== exp && n < 30) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		check({8'h00, socket_state}, {8'h00, exp});
		if (socket_state !== exp)
			tally_and_finish();
	endtask : wait_state
	task automatic conn;
		open_sock(8'h01);
		wait_state(`SCEV_ST_OPENED_TCP);
		ev(7);
		wait_state(`SCEV_ST_CONNECTED);
	endtask : conn
	// ==========================================================
	// scenarios
	task automatic sc_reset;
		rd(`SCEV_OFS_FLAGS, 8'h00);
		rd(`SCEV_OFS_STATE, `SCEV_ST_IDLE);
		rd(`SCEV_OFS_MASK, 8'hFF);
		rd(`SCEV_OFS_CMD, 8'h00);
		rd(16'h1234, 8'h00);
	endtask : sc_reset
	task automatic sc_flags;
		conn();
		rd(`SCEV_OFS_FLAGS, 8'h01);
		check({15'h0000, summary_bit}, 16'h0001);
		wr(`SCEV_OFS_FLAGS, 8'hFE);
		rd(`SCEV_OFS_FLAGS, 8'h01);
		wr(`SCEV_OFS_FLAGS, 8'h01);
		rd(`SCEV_OFS_FLAGS, 8'h00);
		rd(`SCEV_OFS_SUMMARY, 8'h00);
		check({15'h0000, summary_bit}, 16'h0000);
		wr(`SCEV_OFS_MASK, 8'hFB);
		ev(6);
		rd(`SCEV_OFS_FLAGS, 8'h00);
		ev(1);
		rd(`SCEV_OFS_FLAGS, 8'h00);
		wr(`SCEV_OFS_MASK, 8'hFF);
		ev(6);
		rd(`SCEV_OFS_FLAGS, 8'h04);
		wr(`SCEV_OFS_FLAGS, 8'hFF);
	endtask : sc_flags
	task automatic sc_send;
		@(posedge sys_clk);
		tx_read_ptr <= 16'h0010;
		tx_write_ptr <= 16'h0050;
		rx_read_ptr <= 16'h0ABC;
		cmd(`SCEV_CMD_SEND);
		check({6'h00, act_seen}, 16'h0100);
		check(tx_len, 16'h0040);
		rd(`SCEV_OFS_CMD, 8'h00);
		rd(`SCEV_OFS_FLAGS, 8'h10);
		wr(`SCEV_OFS_FLAGS, 8'hFF);
		cmd(`SCEV_CMD_RX_CONSUME);
		check({6'h00, act_seen}, 16'h0020);
		check(rx_free_to, 16'h0ABC);
		cmd(`SCEV_CMD_PPP_START);
		check({6'h00, act_seen}, 16'h0000);
		cmd(`SCEV_CMD_KEEPALIVE);
		check({6'h00, act_seen}, 16'h0040);
		ev(4);
		wait_state(`SCEV_ST_IDLE);
		rd(`SCEV_OFS_FLAGS, 8'h08);
		wr(`SCEV_OFS_FLAGS, 8'hFF);
	endtask : sc_send
	task automatic sc_close;
		conn();
		cmd(`SCEV_CMD_GRACEFUL_CLOSE);
		check({6'h00, act_seen[9], 9'h000}, 16'h0200);
		wait_state(`SCEV_ST_IDLE);
		conn();
		ev(10);
		rd(`SCEV_OFS_FLAGS, 8'h03);
		cmd(`SCEV_CMD_GRACEFUL_CLOSE);
		check({6'h00, act_seen[9], 9'h000}, 16'h0200);
		wait_state(`SCEV_ST_IDLE);
		conn();
		cmd(`SCEV_CMD_CLOSE);
		wait_state(`SCEV_ST_IDLE);
		check({6'h00, act_seen}, 16'h0000);
		conn();
		ev(8);
		wait_state(`SCEV_ST_IDLE);
		open_sock(8'h01);
		wait_state(`SCEV_ST_OPENED_TCP);
		ev(8);
		wait_state(`SCEV_ST_IDLE);
		wr(`SCEV_OFS_FLAGS, 8'hFF);
	endtask : sc_close
	task automatic sc_udp_ppp;
		open_sock(8'h02);
		cmd(`SCEV_CMD_TX_FIXED_HW);
		check({6'h00, act_seen}, 16'h0180);
		ev(3);
		rd(`SCEV_OFS_FLAGS, 8'h18);
		cmd(`SCEV_CMD_CLOSE);
		wr(`SCEV_OFS_FLAGS, 8'hFF);
		// ppp commands only go to socket 0 in ppp mode
		open_sock(8'h05);
		for (int c = 8'h23; c <= 8'h27; c++) begin
			cmd(8'(c));
			check({6'h00, act_seen}, 16'h0010 >> (c - 8'h23));
		end
		ev(0);
		ev(1);
		ev(2);
		rd(`SCEV_OFS_FLAGS, 8'hE0);
	endtask : sc_udp_ppp
	// ==========================================================
	// main sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		sc_reset();
		sc_flags();
		sc_send();
		sc_close();
		sc_udp_ppp();
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
